// *** haptic_input_mode_trigger_ctrl.sv ***
// device end: mode decode, trigger pin handling, sequencer and drive scaling
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
module haptic_input_mode_trigger_ctrl
   import haptic_pkg::*;
#(
   parameter int EFFECT_CYCLES = 1000,
   parameter int WAIT_CYCLES = WAIT_UNIT_CYCLES,
   parameter logic [2:0] ID_CODE = 3'h5 // arbitrary identity value
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   haptic_link_if.dev link,
   output logic [7:0] drive_mag,
   output logic drive_neg,
   output logic phase_shift,
   output logic analog_active,
   output logic audio_active,
   output logic playing,
   output logic [2:0] slot
);
   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic trig_s1;
      logic trig_s2;
      logic trig_p;
      logic [7:0] mode;
      logic [7:0] ampl;
      logic [7:0] clamp;
      logic [7:0] rated;
      logic [7:0] cfg;
      logic [SEQ_SLOTS-1:0][7:0] seq;
      logic go;
      seq_state_t st;
      logic [2:0] slot;
      logic [31:0] cnt;
      logic [7:0] rdata;
      logic [7:0] mag;
      logic neg;
      logic phase;
      logic analog;
      logic audio;
   } dev_state_t;

   dev_state_t q, n;

   function automatic dev_state_t power_up();
      dev_state_t s;
      s = '0;
      s.mode = MODE_DEFAULT;
      s.clamp = CLAMP_DEFAULT;
      s.rated = RATED_DEFAULT;
      s.cfg = CFG_DEFAULT;
      s.seq[0] = SEQ0_DEFAULT;
      s.st = SEQ_IDLE;
      return s;
   endfunction : power_up

   // cycles a slot occupies, less one: an effect or a multiple of the wait
   function automatic logic [31:0] slot_len(input logic [7:0] v);
      logic [31:0] len;
      len = 32'(EFFECT_CYCLES);
      if (v[SEQ_WAIT_BIT])
         len = 32'(v[6:0]) * 32'(WAIT_CYCLES);
      if (len == 32'h0)
         len = 32'h1;
      return len - 32'h1;
   endfunction : slot_len

   // a * b / 256, rounded down
   function automatic logic [7:0] scale(input logic [7:0] a,
      input logic [7:0] b);
      logic [15:0] p;
      p = 16'(a) * 16'(b);
      return p[15:8];
   endfunction : scale

   // distance from mid-scale, doubled and saturated to full scale
   function automatic logic [7:0] span(input logic [7:0] u);
      logic [8:0] d;
      if (u >= MID_SCALE)
         d = {1'b0, u - MID_SCALE} << 1;
      else
         d = {1'b0, MID_SCALE - u} << 1;
      return d[8] ? FULL_SCALE : d[7:0];
   endfunction : span

   logic rise;
   logic standby;
   logic [2:0] mode_f;
   logic trig_mode;
   logic [2:0] idx;
   logic [3:0] nxt;
   logic use_in;
   logic [7:0] u;
   logic [7:0] m;
   logic ng;
   logic [1:0] loop_f;

   always_comb
   begin
      n = q;
      idx = '0;
      nxt = '0;
      use_in = 1'b0;
      u = MID_SCALE;
      m = '0;
      ng = 1'b0;
      // enable and trigger pins cross into this clock before any use; in_level is used as it arrives
      n.en_s1 = link.en;
      n.en_s2 = q.en_s1;
      n.trig_s1 = link.trig;
      n.trig_s2 = q.trig_s1;
      n.trig_p = q.trig_s2;
      rise = q.trig_s2 & ~q.trig_p;
      mode_f = q.mode[2:0];
      loop_f = q.cfg[CFG_LOOP_LO +: 2];
      standby = q.mode[MODE_STANDBY_BIT] | ~q.en_s2;
      trig_mode = (mode_f == MODE_EDGE) || (mode_f == MODE_LEVEL);

      // sequencer: slot 0 first, stops on zero or after the last slot
      case (q.st)
         SEQ_IDLE:
         begin
            if (q.go && !standby
               && (trig_mode || mode_f == MODE_INTERNAL))
            begin
               n.slot = '0;
               if (q.seq[0] == 8'h00)
                  n.st = SEQ_DONE;
               else
               begin
                  n.st = SEQ_PLAY;
                  n.cnt = slot_len(q.seq[0]);
               end
            end
         end
         SEQ_PLAY:
         begin
            nxt = {1'b0, q.slot} + 4'h1;
            if (!q.go || standby)
               n.st = SEQ_IDLE;
            else if (q.cnt != 32'h0)
               n.cnt = q.cnt - 32'h1;
            else if (nxt == 4'(SEQ_SLOTS) || q.seq[nxt[2:0]] == 8'h00)
            begin
               n.st = SEQ_DONE;
               if (mode_f != MODE_LEVEL)
                  n.go = 1'b0;
            end
            else
            begin
               n.slot = nxt[2:0];
               n.cnt = slot_len(q.seq[nxt[2:0]]);
            end
         end
         SEQ_DONE:
         begin
            // level mode holds the start bit high; wait for the pin to drop
            if (!q.go)
               n.st = SEQ_IDLE;
         end
         default:
            n.st = SEQ_IDLE;
      endcase

      // register port; writes are taken only while enabled
      if (link.wr && q.en_s2)
      begin
         idx = 3'(link.addr - REG_SEQ0);
         if (link.addr == REG_MODE)
            n.mode = link.wdata;
         else if (link.addr == REG_AMPL)
            n.ampl = link.wdata;
         else if (link.addr == REG_CLAMP)
            n.clamp = link.wdata;
         else if (link.addr == REG_RATED)
            n.rated = link.wdata;
         else if (link.addr == REG_CFG)
            n.cfg = link.wdata;
         else if (link.addr == REG_GO)
            n.go = link.wdata[0];
         else if (link.addr >= REG_SEQ0
            && link.addr < REG_SEQ0 + 8'(SEQ_SLOTS))
            n.seq[idx] = link.wdata;
      end

      // pin trigger comes after the write so the pin wins a collision
      if (mode_f == MODE_EDGE && rise)
         n.go = ~q.go;
      else if (mode_f == MODE_LEVEL)
         n.go = q.trig_s2;

      n.rdata = 8'h00;
      if (link.rd)
      begin
         idx = 3'(link.addr - REG_SEQ0);
         if (link.addr == REG_STATUS)
         begin
            n.rdata = {ID_CODE, 5'h00};
            n.rdata[STATUS_PLAY_BIT] = (q.st == SEQ_PLAY);
         end
         else if (link.addr == REG_MODE)
            n.rdata = q.mode;
         else if (link.addr == REG_AMPL)
            n.rdata = q.ampl;
         else if (link.addr == REG_CLAMP)
            n.rdata = q.clamp;
         else if (link.addr == REG_RATED)
            n.rdata = q.rated;
         else if (link.addr == REG_CFG)
            n.rdata = q.cfg;
         else if (link.addr == REG_GO)
            n.rdata = {7'h00, q.go};
         else if (link.addr >= REG_SEQ0
            && link.addr < REG_SEQ0 + 8'(SEQ_SLOTS))
            n.rdata = q.seq[idx];
      end

      // input value selection
      n.analog = !standby && mode_f == MODE_INPUT
         && q.cfg[CFG_ANALOG_SEL];
      n.audio = !standby && mode_f == MODE_AUDIO
         && q.cfg[CFG_AC_COUPLING_ENABLE] && q.cfg[CFG_ANALOG_SEL];
      if (!standby && mode_f == MODE_INPUT)
      begin
         use_in = 1'b1;
         u = link.in_level; // full code is the reference level
      end
      else if (!standby && mode_f == MODE_AMPL)
      begin
         use_in = 1'b1;
         // signed data is offset to the same mid-scale origin
         u = q.cfg[CFG_FORMAT] ? q.ampl : (q.ampl ^ MID_SCALE);
      end
      else if (q.st == SEQ_PLAY && !q.seq[q.slot][SEQ_WAIT_BIT])
      begin
         use_in = 1'b1;
         u = FULL_SCALE;
      end

      // drive shaping per loop mode
      if (n.audio)
         m = scale(span(link.in_level), q.rated);
      else if (use_in)
      begin
         case (loop_f)
            LOOP_OPEN:
            begin
               m = scale(span(u), q.clamp);
               ng = (u < MID_SCALE);
            end
            LOOP_CLOSED_UNI:
               m = scale(u, q.rated);
            default:
               m = (u < MID_SCALE) ? 8'h00 : scale(span(u), q.rated);
         endcase
         if (m > q.clamp)
            m = q.clamp;
      end
      n.mag = m;
      // reverse drive: rotating mass turns back, linear shifts phase
      n.neg = ng && !q.cfg[CFG_LRA];
      n.phase = ng && q.cfg[CFG_LRA];

      if (link.wr && q.en_s2 && link.addr == REG_MODE
         && link.wdata[MODE_RESET_BIT])
         n = power_up();
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         q <= power_up();
      else
         q <= n;
   end

   assign link.rdata = q.rdata;
   assign drive_mag = q.mag;
   assign drive_neg = q.neg;
   assign phase_shift = q.phase;
   assign analog_active = q.analog;
   assign audio_active = q.audio;
   assign playing = (q.st == SEQ_PLAY);
   assign slot = q.slot;
endmodule : haptic_input_mode_trigger_ctrl

// *** haptic_pkg.sv ***
// constants and types shared by the haptic trigger device and its host
// Notes on behaviour
// - analog input needs mode 3, select 1
// - analog input drives until standby or mode change
// - reference level full, half is fifty percent
// - audio mode: mode 4, coupling and select set
// - mode 1 edge trigger, mode 2 level
// - pin fires queued sequence via start bit
// - rising edge sets start bit
// - writing zero to start bit cancels playback
// - rising edge while set cancels and clears
// - falling edge ignored in edge mode
// - level mode: start bit follows pin
// - host holds pin high whole waveform
// - enable low acts as standby, keeps registers
// - host writes only while enable high
// - soft reset returns power-up state
// - open loop: clamp full scale, mid zero
// - negative: reverse rotation or half-cycle phase
// - amplitude eight bits, signed or unsigned
// - host: open-loop linear only with pulse input
// - closed loop: rated full scale, clamp ceiling
// - host uses unsigned format in uni-directional
// - bi-directional: below mid gives zero, default
// - sequence from slot one, stop zero or eight
package haptic_pkg;
   // device register offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h01;
   localparam logic [7:0] REG_AMPL = 8'h02;
   localparam logic [7:0] REG_SEQ0 = 8'h04;
   localparam logic [7:0] REG_GO = 8'h0C;
   localparam logic [7:0] REG_CLAMP = 8'h16;
   localparam logic [7:0] REG_RATED = 8'h17;
   localparam logic [7:0] REG_CFG = 8'h1A;
   // field positions and reset values
   localparam int MODE_RESET_BIT = 7;
   localparam int MODE_STANDBY_BIT = 6;
   localparam int STATUS_PLAY_BIT = 4;
   localparam int CFG_ANALOG_SEL = 0;
   localparam int CFG_AC_COUPLING_ENABLE = 1;
   localparam int CFG_FORMAT = 2;
   localparam int CFG_LRA = 3;
   localparam int CFG_LOOP_LO = 4;
   localparam int SEQ_WAIT_BIT = 7;
   localparam logic [7:0] MODE_DEFAULT = 8'h40;
   localparam logic [7:0] SEQ0_DEFAULT = 8'h01;
   localparam logic [7:0] CLAMP_DEFAULT = 8'hFF;
   localparam logic [7:0] RATED_DEFAULT = 8'h80;
   localparam logic [7:0] CFG_DEFAULT = 8'h00;
   localparam logic [7:0] MID_SCALE = 8'h80;
   localparam logic [7:0] FULL_SCALE = 8'hFF;
   localparam int SEQ_SLOTS = 8;
   // mode field values
   localparam logic [2:0] MODE_INTERNAL = 3'h0;
   localparam logic [2:0] MODE_EDGE = 3'h1;
   localparam logic [2:0] MODE_LEVEL = 3'h2;
   localparam logic [2:0] MODE_INPUT = 3'h3;
   localparam logic [2:0] MODE_AUDIO = 3'h4;
   localparam logic [2:0] MODE_AMPL = 3'h5;
   // drive loop selection in the configuration register
   localparam logic [1:0] LOOP_CLOSED_BI = 2'h0;
   localparam logic [1:0] LOOP_CLOSED_UNI = 2'h1;
   localparam logic [1:0] LOOP_OPEN = 2'h2;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAIT_UNIT_MS = 10;
   localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TRIG_PULSE_NS = 1000;
   localparam int TRIG_PULSE_CYCLES =
      (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host controller register offsets
   localparam logic [3:0] H_ADDR = 4'h0;
   localparam logic [3:0] H_WDATA = 4'h1;
   localparam logic [3:0] H_CMD = 4'h2;
   localparam logic [3:0] H_RDATA = 4'h3;
   localparam logic [3:0] H_PINS = 4'h4;
   localparam logic [3:0] H_LEVEL = 4'h5;
   localparam logic [3:0] H_STATUS = 4'h6;
   localparam int CMD_WRITE_BIT = 0;
   localparam int CMD_READ_BIT = 1;
   localparam int PIN_EN_BIT = 0;
   localparam int PIN_TRIG_BIT = 1;
   localparam int PIN_PULSE_BIT = 2;
   localparam int STAT_PULSE_BIT = 0;
   localparam int STAT_REFUSED_BIT = 1;
   localparam int STAT_RDPEND_BIT = 2;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_PLAY, SEQ_DONE} seq_state_t;
endpackage : haptic_pkg

// *** haptic_link_if.sv ***
// link between the haptic device and its host: pins and register port
`timescale 1ns/100ps
interface haptic_link_if (input wire logic ref_clk);
   logic en;
   logic trig;
   logic [7:0] in_level;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   modport dev (input en, trig, in_level, addr, wdata, wr, rd,
      output rdata);
   modport host (output en, trig, in_level, addr, wdata, wr, rd,
      input rdata);
endinterface : haptic_link_if

// *** haptic_host_ctrl.sv ***
// host end: turns software register orders into pin levels and device accesses
`timescale 1ns/100ps
module haptic_host_ctrl
   import haptic_pkg::*;
#(
   parameter int PULSE_CYCLES = TRIG_PULSE_CYCLES
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   haptic_link_if.host link,
   input wire logic [3:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);
   typedef struct packed {
      logic en;
      logic trig_lvl;
      logic pulse_on;
      logic trig;
      logic [7:0] level;
      logic [7:0] dev_addr;
      logic [7:0] dev_wdata;
      logic [7:0] dev_rdata;
      logic wr;
      logic rd;
      logic rd_pend;
      logic refused;
      logic [15:0] pcnt;
      logic [7:0] sw_rdata;
   } host_state_t;

   host_state_t q, n;
   logic [7:0] stat;

   always_comb
   begin
      n = q;
      n.wr = 1'b0;
      n.rd = 1'b0;
      n.rd_pend = q.rd;
      if (q.rd_pend)
         n.dev_rdata = link.rdata;
      if (q.pulse_on)
      begin
         if (q.pcnt == 16'h0)
            n.pulse_on = 1'b0;
         else
            n.pcnt = q.pcnt - 16'h1;
      end
      stat = 8'h00;
      stat[STAT_PULSE_BIT] = q.pulse_on;
      stat[STAT_REFUSED_BIT] = q.refused;
      stat[STAT_RDPEND_BIT] = q.rd | q.rd_pend;

      if (sw_wr)
      begin
         case (sw_addr)
            H_ADDR: n.dev_addr = sw_wdata;
            H_WDATA: n.dev_wdata = sw_wdata;
            H_LEVEL: n.level = sw_wdata;
            H_CMD:
            begin
               // device writes are refused while the enable pin is low
               if (sw_wdata[CMD_WRITE_BIT] && !q.en)
                  n.refused = 1'b1;
               else if (sw_wdata[CMD_WRITE_BIT])
                  n.wr = 1'b1;
               else if (sw_wdata[CMD_READ_BIT])
                  n.rd = 1'b1;
            end
            H_PINS:
            begin
               n.en = sw_wdata[PIN_EN_BIT];
               // level trigger: software holds it for the whole effect
               n.trig_lvl = sw_wdata[PIN_TRIG_BIT];
               if (sw_wdata[PIN_PULSE_BIT])
               begin
                  // a short pulse is enough in edge mode
                  n.pulse_on = 1'b1;
                  n.pcnt = 16'(PULSE_CYCLES - 1);
               end
            end
            H_STATUS:
            begin
               // writing one clears the sticky refusal flag
               if (sw_wdata[STAT_REFUSED_BIT])
                  n.refused = 1'b0;
            end
            default:
            begin
            end
         endcase
      end
      n.trig = n.trig_lvl | n.pulse_on;

      n.sw_rdata = 8'h00;
      if (sw_rd)
      begin
         case (sw_addr)
            H_ADDR: n.sw_rdata = q.dev_addr;
            H_WDATA: n.sw_rdata = q.dev_wdata;
            H_RDATA: n.sw_rdata = q.dev_rdata;
            H_PINS: n.sw_rdata = {5'h00, q.pulse_on, q.trig_lvl, q.en};
            H_LEVEL: n.sw_rdata = q.level;
            H_STATUS: n.sw_rdata = stat;
            default: n.sw_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= n;
   end

   assign link.en = q.en;
   assign link.trig = q.trig;
   assign link.in_level = q.level;
   assign link.addr = q.dev_addr;
   assign link.wdata = q.dev_wdata;
   assign link.wr = q.wr;
   assign link.rd = q.rd;
   assign sw_rdata = q.sw_rdata;
endmodule : haptic_host_ctrl

// *** haptic_link_assertions.sv ***
// checker watching the register link between the host and device ends
`timescale 1ns/100ps
module haptic_link_assertions
   import haptic_pkg::*;
#(
   parameter logic [2:0] ID_CODE = 3'h5 // arbitrary identity value
)(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic en,
   input wire logic trig,
   input wire logic [7:0] in_level,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata
);
   logic [2:0] en_q;
   logic [7:0] ampl_q;
   logic acc;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // a write counts only once the device's enable synchroniser saw en
   assign acc = wr && en && (&en_q);
   always_ff @(posedge ref_clk)
   begin
      en_q <= {en_q[1:0], en};
      if (sys_rst || (acc && addr == REG_MODE && wdata[MODE_RESET_BIT]))
         ampl_q <= 8'h00;
      else if (acc && addr == REG_AMPL)
         ampl_q <= wdata;
   end
   sequence soft_rst_s;
      acc && addr == REG_MODE && wdata[MODE_RESET_BIT];
   endsequence
   sequence mode_rd_s;
      rd && addr == REG_MODE;
   endsequence
   AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not idle");
   AST_WR_PULSE: assert property (wr |=> !wr)
      else $error("write strobe too long");
   AST_RD_PULSE: assert property (rd |=> !rd)
      else $error("read strobe too long");
   AST_ONE_STROBE: assert property (!(wr && rd))
      else $error("read and write together");
   AST_WR_EN: assert property (wr |-> en)
      else $error("write while enable low");
   AST_SOFT_RESET: assert property (soft_rst_s ##1
      ((!wr) throughout (1'b1 ##[0:9] mode_rd_s)) |=> rdata == MODE_DEFAULT)
      else $error("soft reset left mode register changed");
   AST_STATUS_ID: assert property (rd && addr == REG_STATUS
      |=> rdata[7:5] == ID_CODE)
      else $error("status identity field wrong");
   AST_AMPL_KEEP: assert property (rd && addr == REG_AMPL
      |=> rdata == ampl_q)
      else $error("amplitude register lost its value");
   AST_UNMAPPED: assert property (rd && addr >= 8'h20 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : haptic_link_assertions

// *** tb_top.sv ***
// self-checking bench joining the host and device ends of the haptic link
`timescale 1ns/100ps
module tb_top
   import haptic_pkg::*;
;
   localparam int E = 40;
   localparam int W = 20;
   localparam logic [2:0] ID = 3'h6; // arbitrary identity value
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] cfg;
      logic [7:0] lvl;
      logic [4:0] x; // analog, audio, reverse, phase, zero drive
      logic [4:0] m; // which of those are checked
   } row_t;
   row_t rows [12] = '{
      '{8'h03, 8'h01, 8'h80, 5'b10001, 5'b11111},
      '{8'h03, 8'h00, 8'h80, 5'b00000, 5'b11000},
      '{8'h04, 8'h03, 8'h80, 5'b01000, 5'b11000},
      '{8'h04, 8'h01, 8'h80, 5'b00000, 5'b11000},
      '{8'h04, 8'h02, 8'h80, 5'b00000, 5'b11000},
      '{8'h03, 8'h01, 8'h40, 5'b10001, 5'b11111},
      '{8'h03, 8'h21, 8'h40, 5'b10100, 5'b11110},
      '{8'h03, 8'h28, 8'h40, 5'b00010, 5'b11110},
      '{8'h03, 8'h21, 8'h80, 5'b10001, 5'b11111},
      '{8'h03, 8'h21, 8'hFF, 5'b10000, 5'b10101},
      '{8'h03, 8'h11, 8'h40, 5'b10000, 5'b10101},
      '{8'h05, 8'h14, 8'h80, 5'b00001, 5'b11111}
   };
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [7:0] sw_rdata, drive_mag, v;
   logic drive_neg, phase_shift, analog_active, audio_active, playing;
   logic [2:0] slot;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #5 ref_clk = ~ref_clk;
   haptic_link_if link (.ref_clk(ref_clk));
   haptic_input_mode_trigger_ctrl #(.EFFECT_CYCLES(E), .WAIT_CYCLES(W),
      .ID_CODE(ID))
      u_haptic_input_mode_trigger_ctrl (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .link(link), .drive_mag(drive_mag),
      .drive_neg(drive_neg), .phase_shift(phase_shift),
      .analog_active(analog_active), .audio_active(audio_active),
      .playing(playing), .slot(slot));
   haptic_host_ctrl #(.PULSE_CYCLES(4)) u_haptic_host_ctrl (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   haptic_link_assertions #(.ID_CODE(ID)) u_haptic_link_assertions (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst), .en(link.en), .trig(link.trig),
      .in_level(link.in_level), .addr(link.addr), .wdata(link.wdata),
      .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk1
   task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
   endtask : sw_w
   task automatic sw_r(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge ref_clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask : sw_r
   task automatic dev_w(input logic [7:0] a, input logic [7:0] d);
      sw_w(H_ADDR, a);
      sw_w(H_WDATA, d);
      sw_w(H_CMD, 8'h01);
      repeat (2) @(posedge ref_clk);
   endtask : dev_w
   task automatic dev_r(input logic [7:0] a, output logic [7:0] d);
      sw_w(H_ADDR, a);
      sw_w(H_CMD, 8'h02);
      repeat (4) @(posedge ref_clk);
      sw_r(H_RDATA, d);
   endtask : dev_r
   // looks only after the edge has settled, never in the launching step
   task automatic wait_play(input logic x);
      #1;
      for (int i = 0; i < 60 && playing !== x; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk1(playing, x);
   endtask : wait_play
   // counts cycles of one playback and the highest slot reached
   task automatic play_len(output int n, output logic [2:0] mx);
      n = 0;
      mx = 3'h0;
      wait_play(1'b1);
      while (playing === 1'b1 && n < 1000)
      begin
         @(posedge ref_clk);
         #1 n++;
         if (slot > mx)
            mx = slot;
      end
   endtask : play_len
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         finish_test();
      end
   end
   initial
   begin
      int n;
      logic [2:0] mx;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      sw_w(H_PINS, 8'h01);
      foreach (rows[i])
      begin
         dev_w(REG_CFG, rows[i].cfg);
         sw_w(H_LEVEL, rows[i].lvl);
         dev_w(REG_MODE, rows[i].mode);
         repeat (8) @(posedge ref_clk);
         #1 chk8({3'h0, {analog_active, audio_active, drive_neg, phase_shift,
            drive_mag === 8'h00} & rows[i].m},
            {3'h0, rows[i].x & rows[i].m});
      end
      $display("done: input modes");
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1 chk1(analog_active, 1'b0);
      chk8(drive_mag, 8'h00);
      dev_r(REG_STATUS, v);
      chk8(v, {ID, 5'h00});
      dev_r(REG_MODE, v);
      chk8(v, MODE_DEFAULT);
      dev_r(REG_CLAMP, v);
      chk8(v, CLAMP_DEFAULT);
      dev_r(REG_CFG, v);
      chk8(v, CFG_DEFAULT);
      dev_r(8'h30, v);
      chk8(v, 8'h00);
      // enable still low, so the host must refuse this write
      dev_w(REG_AMPL, 8'h11);
      sw_r(H_STATUS, v);
      chk1(v[STAT_REFUSED_BIT], 1'b1);
      sw_w(H_STATUS, 8'h02);
      sw_r(H_STATUS, v);
      chk1(v[STAT_REFUSED_BIT], 1'b0);
      $display("done: reset and refusal");
      sw_w(H_PINS, 8'h01);
      repeat (4) @(posedge ref_clk);
      dev_w(REG_AMPL, 8'h5A);
      dev_w(REG_CFG, 8'h01);
      dev_w(REG_MODE, 8'h03);
      sw_w(H_PINS, 8'h00);
      repeat (6) @(posedge ref_clk);
      #1 chk1(analog_active, 1'b0);
      sw_w(H_PINS, 8'h01);
      repeat (4) @(posedge ref_clk);
      dev_r(REG_AMPL, v);
      chk8(v, 8'h5A);
      dev_w(REG_CLAMP, 8'h33);
      dev_w(REG_MODE, 8'h80);
      dev_r(REG_MODE, v);
      chk8(v, MODE_DEFAULT);
      dev_r(REG_CLAMP, v);
      chk8(v, CLAMP_DEFAULT);
      $display("done: standby and soft reset");
      dev_w(REG_SEQ0 + 8'h01, 8'h02);
      dev_w(REG_MODE, 8'h01);
      sw_w(H_PINS, 8'h05);
      play_len(n, mx);
      chk8(8'(n / E), 8'h02);
      dev_r(REG_GO, v);
      chk8(v, 8'h00);
      sw_w(H_PINS, 8'h05);
      wait_play(1'b1);
      repeat (6) @(posedge ref_clk);
      sw_w(H_PINS, 8'h05);
      wait_play(1'b0);
      dev_r(REG_GO, v);
      chk8(v, 8'h00);
      sw_w(H_PINS, 8'h05);
      wait_play(1'b1);
      dev_w(REG_GO, 8'h00);
      wait_play(1'b0);
      for (int i = 0; i < SEQ_SLOTS; i++)
         dev_w(REG_SEQ0 + 8'(i), 8'h01);
      // last slot is a pause of one wait unit instead of an effect
      dev_w(REG_SEQ0 + 8'h07, 8'h81);
      sw_w(H_PINS, 8'h05);
      play_len(n, mx);
      chk1(n == 7 * E + W, 1'b1);
      chk8({5'h00, mx}, 8'h07);
      $display("done: edge trigger");
      dev_w(REG_MODE, 8'h02);
      sw_w(H_PINS, 8'h03);
      wait_play(1'b1);
      dev_r(REG_GO, v);
      chk8(v, 8'h01);
      dev_r(REG_STATUS, v);
      chk8(v, {ID, 5'h10});
      sw_w(H_PINS, 8'h01);
      wait_play(1'b0);
      dev_r(REG_GO, v);
      chk8(v, 8'h00);
      $display("done: level trigger");
      dev_w(REG_MODE, 8'h00);
      dev_w(REG_GO, 8'h01);
      wait_play(1'b1);
      chk8({5'h00, slot}, 8'h00);
      $display("done: internal trigger");
      finish_test();
   end
endmodule : tb_top
